// File: rtl/sos_params.svh
// constants for the status output selector: register offsets, field positions, reset values
// assumes a 32-bit apb slave with byte addresses and 8 decoded address bits
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH

`define SOS_OFF_SEL 8'h00
`define SOS_OFF_ANA 8'h04
`define SOS_OFF_FREQ_SET 8'h08
`define SOS_OFF_FREQ_12 8'h0C
`define SOS_OFF_START_FREQ 8'h10
`define SOS_OFF_UV_LIMIT 8'h14
`define SOS_OFF_PID_LIMITS 8'h18
`define SOS_OFF_COUNT_SET 8'h1C
`define SOS_OFF_FREQ_RANGE 8'h20
`define SOS_OFF_RATED_CUR 8'h24
`define SOS_OFF_STATUS 8'h28
`define SOS_OFF_COUNT 8'h2C

`define SOS_SEL_R1_LSB 0
`define SOS_SEL_R2_LSB 8
`define SOS_SEL_CO_LSB 16
`define SOS_ANA_V_LSB 0
`define SOS_ANA_I_LSB 8
`define SOS_HI_LSB 16

`define SOS_RST_R1 6'h01
`define SOS_RST_R2 6'h02
`define SOS_RST_CO 6'h03
`define SOS_RST_VSRC 3'h0
`define SOS_RST_ISRC 3'h1
`define SOS_RST_FINAL 16'h0064
`define SOS_RST_MID 16'h0032
`define SOS_RST_ZERO16 16'h0000
`define SOS_RST_MAXF 16'h1388
`define SOS_RST_RATED 16'h0064

`define SOS_CODE_MAX 6'h20
`define SOS_BUS_FULL_V 17'h003E8
`define SOS_OUT_FULL_V 17'h001FE

`endif

// File: rtl/sos_pkg.sv
// types shared by the status output selector, its checker and its bench
// assumes sos_params.svh is included by the design files
package sos_pkg;

    typedef logic [5:0] func_code_t;
    typedef logic [2:0] ana_src_t;

    typedef struct packed {
        logic running;
        logic fault;
        logic accel;
        logic decel;
        logic timer1_done;
        logic timer2_done;
        logic timer1_start;
        logic timer2_start;
        logic cable_open;
        logic overload;
        logic over_torque;
    } drive_flags_t;

    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] set_freq;
        logic [15:0] bus_volt;
        logic [15:0] out_volt;
        logic [15:0] out_current;
        logic [15:0] pid_feedback;
    } drive_meas_t;

    typedef enum logic [1:0] {
        WIND_IDLE,
        WIND_RUN,
        WIND_DONE
    } wind_state_t;

endpackage

// File: rtl/analog_scaler.sv
// analogue output scaler: maps a value between lo and hi onto 0..full scale
// assumes lo and hi are chosen by the caller; output is registered
`timescale 1ns/1ps
`include "sos_params.svh"

module analog_scaler #(
    parameter int VW = 17,
    parameter int OW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [VW-1:0] value,
    input wire logic [VW-1:0] lo,
    input wire logic [VW-1:0] hi,
    output logic [OW-1:0] scaled
);
    localparam logic [OW-1:0] FULL = {OW{1'b1}};

    wire [VW-1:0] span = (hi > lo) ? VW'(hi - lo) : VW'(1);
    wire [VW-1:0] num = (value > lo) ? VW'(value - lo) : '0;
    // divider kept combinational: the source changes slowly, one cycle is plenty
    wire [VW+OW-1:0] prod = (VW+OW)'(num) * (VW+OW)'(FULL);
    wire [VW+OW-1:0] quot = prod / (VW+OW)'(span);
    wire [OW-1:0] scaled_nxt = (num >= span) ? FULL : quot[OW-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scaled <= '0;
        end else begin
            scaled <= scaled_nxt;
        end
    end

endmodule

// File: rtl/status_output_selector.sv
// status output selector: function-coded relay outputs, counter, step program position,
// winding sequence and analogue output source selection behind an apb register file
// assumes drive status inputs are synchronous to pclk and stage/winding events are one-cycle pulses
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "sos_params.svh"

module status_output_selector
    import sos_pkg::*;
#(
    parameter int STAGES = 8,
    parameter int OUT_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drive_flags_t flags,
    input wire drive_meas_t meas,
    input wire logic step_program_mode,
    input wire logic stage_done,
    input wire logic counter_pulse,
    input wire logic counter_reset,
    input wire logic program_clear,
    input wire logic winding_enable,
    input wire logic winding_done,
    output logic relay_output_one,
    output logic relay_output_two,
    output logic changeover_relay_output,
    output logic undervoltage_alarm,
    output logic cable_alarm,
    output logic winding_active,
    output logic winding_hold,
    output logic [15:0] winding_hold_freq,
    output logic [$clog2(STAGES)-1:0] program_step,
    output logic [OUT_W-1:0] analog_voltage_output,
    output logic [OUT_W-1:0] analog_current_output
);
    localparam int NCODE = 33;
    localparam int SW = $clog2(STAGES);
    localparam logic [SW-1:0] LAST_STEP = SW'(STAGES - 1);

    // a code above 32 is treated like code 0 so a bad write cannot drive a relay
    function automatic logic pick(input func_code_t code, input logic [NCODE-1:0] conds);
        if (code > `SOS_CODE_MAX || code == '0) begin
            return 1'b0;
        end
        return conds[code];
    endfunction

    func_code_t relay1_function_select_r;
    func_code_t relay2_function_select_r;
    func_code_t changeover_relay_function_select_r;
    ana_src_t voltage_out_source_select_r;
    ana_src_t current_out_source_select_r;
    logic [15:0] freq1_r, freq2_r, set_tol_r, start_freq_r, uv_limit_r;
    logic [15:0] pid_upper_r, pid_lower_r;
    logic [15:0] final_count_setting_r, intermediate_count_setting_r;
    logic [15:0] min_freq_r, max_freq_r, rated_cur_r;
    logic [15:0] count_r;
    logic pulse_d_r;
    logic [SW-1:0] step_r;
    logic stage_pulse_r, prog_pulse_r;
    logic tmr1_r, tmr2_r;
    wind_state_t wind_r, wind_nxt;
    logic [15:0] hold_freq_r;
    logic [2:0] relays_r;
    logic uv_alarm_r, cable_alarm_r;

    // apb decode
    wire wr_en = psel && penable && pwrite;
    wire hit_sel = paddr == `SOS_OFF_SEL;
    wire hit_ana = paddr == `SOS_OFF_ANA;
    wire hit_fset = paddr == `SOS_OFF_FREQ_SET;
    wire hit_f12 = paddr == `SOS_OFF_FREQ_12;
    wire hit_sf = paddr == `SOS_OFF_START_FREQ;
    wire hit_uv = paddr == `SOS_OFF_UV_LIMIT;
    wire hit_pid = paddr == `SOS_OFF_PID_LIMITS;
    wire hit_cnt = paddr == `SOS_OFF_COUNT_SET;
    wire hit_rng = paddr == `SOS_OFF_FREQ_RANGE;
    wire hit_rat = paddr == `SOS_OFF_RATED_CUR;
    wire hit_st = paddr == `SOS_OFF_STATUS;
    wire hit_cv = paddr == `SOS_OFF_COUNT;
    wire mapped = hit_sel | hit_ana | hit_fset | hit_f12 | hit_sf | hit_uv | hit_pid |
                  hit_cnt | hit_rng | hit_rat | hit_st | hit_cv;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    wire [31:0] status_word = {8'h00, 5'h00, relays_r, 2'h0, wind_r, uv_alarm_r, cable_alarm_r,
                               tmr2_r, tmr1_r, 8'(step_r)};
    wire [31:0] rd_mux =
        hit_sel ? {10'h000, changeover_relay_function_select_r, 2'h0, relay2_function_select_r,
                   2'h0, relay1_function_select_r} :
        hit_ana ? {21'h000000, current_out_source_select_r, 5'h00, voltage_out_source_select_r} :
        hit_fset ? {16'h0000, set_tol_r} :
        hit_f12 ? {freq2_r, freq1_r} :
        hit_sf ? {16'h0000, start_freq_r} :
        hit_uv ? {16'h0000, uv_limit_r} :
        hit_pid ? {pid_lower_r, pid_upper_r} :
        hit_cnt ? {intermediate_count_setting_r, final_count_setting_r} :
        hit_rng ? {max_freq_r, min_freq_r} :
        hit_rat ? {16'h0000, rated_cur_r} :
        hit_st ? status_word :
        hit_cv ? {16'h0000, count_r} : 32'h00000000;
    assign prdata = (psel && !pwrite) ? rd_mux : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay1_function_select_r <= `SOS_RST_R1;
            relay2_function_select_r <= `SOS_RST_R2;
            changeover_relay_function_select_r <= `SOS_RST_CO;
        end else if (wr_en && hit_sel) begin
            relay1_function_select_r <= pwdata[`SOS_SEL_R1_LSB +: 6];
            relay2_function_select_r <= pwdata[`SOS_SEL_R2_LSB +: 6];
            changeover_relay_function_select_r <= pwdata[`SOS_SEL_CO_LSB +: 6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voltage_out_source_select_r <= `SOS_RST_VSRC;
            current_out_source_select_r <= `SOS_RST_ISRC;
        end else if (wr_en && hit_ana) begin
            voltage_out_source_select_r <= pwdata[`SOS_ANA_V_LSB +: 3];
            current_out_source_select_r <= pwdata[`SOS_ANA_I_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_tol_r <= `SOS_RST_ZERO16;
            freq1_r <= `SOS_RST_ZERO16;
            freq2_r <= `SOS_RST_ZERO16;
            start_freq_r <= `SOS_RST_ZERO16;
            uv_limit_r <= `SOS_RST_ZERO16;
        end else if (wr_en) begin
            if (hit_fset) begin
                set_tol_r <= pwdata[15:0];
            end
            if (hit_f12) begin
                freq1_r <= pwdata[15:0];
                freq2_r <= pwdata[`SOS_HI_LSB +: 16];
            end
            if (hit_sf) begin
                start_freq_r <= pwdata[15:0];
            end
            if (hit_uv) begin
                uv_limit_r <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pid_upper_r <= `SOS_RST_ZERO16;
            pid_lower_r <= `SOS_RST_ZERO16;
            final_count_setting_r <= `SOS_RST_FINAL;
            intermediate_count_setting_r <= `SOS_RST_MID;
            min_freq_r <= `SOS_RST_ZERO16;
            max_freq_r <= `SOS_RST_MAXF;
            rated_cur_r <= `SOS_RST_RATED;
        end else if (wr_en) begin
            if (hit_pid) begin
                pid_upper_r <= pwdata[15:0];
                pid_lower_r <= pwdata[`SOS_HI_LSB +: 16];
            end
            if (hit_cnt) begin
                final_count_setting_r <= pwdata[15:0];
                intermediate_count_setting_r <= pwdata[`SOS_HI_LSB +: 16];
            end
            if (hit_rng) begin
                min_freq_r <= pwdata[15:0];
                max_freq_r <= pwdata[`SOS_HI_LSB +: 16];
            end
            if (hit_rat) begin
                rated_cur_r <= pwdata[15:0];
            end
        end
    end

    // pulse counter; slow pulses only, edge taken from one sampled copy
    wire pulse_edge = counter_pulse && !pulse_d_r;
    wire count_final = count_r >= final_count_setting_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_d_r <= 1'b0;
            count_r <= `SOS_RST_ZERO16;
        end else begin
            pulse_d_r <= counter_pulse;
            if (counter_reset) begin
                count_r <= `SOS_RST_ZERO16;
            end else if (pulse_edge && !count_final) begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    // step program position survives fault and stop; only clear or completion rewinds it
    wire stage_ev = step_program_mode && stage_done;
    wire last_stage = step_r == LAST_STEP;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_r <= '0;
            stage_pulse_r <= 1'b0;
            prog_pulse_r <= 1'b0;
        end else begin
            stage_pulse_r <= stage_ev;
            prog_pulse_r <= stage_ev && last_stage;
            if (program_clear) begin
                step_r <= '0;
            end else if (stage_ev) begin
                step_r <= last_stage ? '0 : SW'(step_r + 1'b1);
            end
        end
    end

    // timer reached flags: a new reach in the same cycle as removal still loses, start gone means off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr1_r <= 1'b0;
            tmr2_r <= 1'b0;
        end else begin
            tmr1_r <= flags.timer1_start && (tmr1_r || flags.timer1_done);
            tmr2_r <= flags.timer2_start && (tmr2_r || flags.timer2_done);
        end
    end

    // winding sequence
    always_comb begin
        wind_nxt = wind_r;
        unique case (wind_r)
            WIND_IDLE: begin
                if (winding_enable && flags.running) begin
                    wind_nxt = WIND_RUN;
                end
            end
            WIND_RUN: begin
                if (!flags.running) begin
                    wind_nxt = WIND_IDLE;
                end else if (winding_done) begin
                    wind_nxt = WIND_DONE;
                end
            end
            WIND_DONE: begin
                if (!flags.running) begin
                    wind_nxt = WIND_IDLE;
                end
            end
            default: wind_nxt = WIND_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wind_r <= WIND_IDLE;
            hold_freq_r <= `SOS_RST_ZERO16;
        end else begin
            wind_r <= wind_nxt;
            if (wind_r == WIND_RUN && wind_nxt == WIND_DONE) begin
                hold_freq_r <= meas.out_freq;
            end
        end
    end

    assign winding_active = wind_r == WIND_RUN;
    assign winding_hold = wind_r == WIND_DONE;
    assign winding_hold_freq = hold_freq_r;
    assign program_step = step_r;

    // condition vector indexed by function code; unused codes stay low
    wire uv_now = meas.bus_volt < uv_limit_r;
    logic [NCODE-1:0] conds;
    always_comb begin
        conds = '0;
        conds[1] = flags.running;
        conds[2] = meas.out_freq >= meas.set_freq;
        conds[3] = flags.fault;
        conds[4] = meas.out_freq < start_freq_r;
        conds[5] = meas.out_freq >= freq1_r;
        conds[6] = meas.out_freq >= freq2_r;
        conds[7] = flags.accel;
        conds[8] = flags.decel;
        conds[9] = uv_now;
        conds[10] = tmr1_r;
        conds[11] = tmr2_r;
        conds[12] = stage_pulse_r;
        conds[13] = prog_pulse_r;
        conds[14] = meas.pid_feedback > pid_upper_r;
        conds[15] = meas.pid_feedback < pid_lower_r;
        conds[16] = flags.cable_open;
        conds[17] = flags.overload;
        conds[18] = flags.over_torque;
        conds[26] = wind_r == WIND_DONE;
        conds[27] = count_final;
        conds[28] = count_r >= intermediate_count_setting_r;
    end

    wire func_code_t sels[3] = '{relay1_function_select_r, relay2_function_select_r,
                                 changeover_relay_function_select_r};

    // registered so a selector rewrite cannot glitch a relay coil
    for (genvar g = 0; g < 3; g++) begin : g_relay
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                relays_r[g] <= 1'b0;
            end else begin
                relays_r[g] <= pick(sels[g], conds);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_alarm_r <= 1'b0;
            cable_alarm_r <= 1'b0;
        end else begin
            uv_alarm_r <= uv_now;
            cable_alarm_r <= flags.cable_open;
        end
    end

    assign relay_output_one = relays_r[0];
    assign relay_output_two = relays_r[1];
    assign changeover_relay_output = relays_r[2];
    assign undervoltage_alarm = uv_alarm_r;
    assign cable_alarm = cable_alarm_r;

    // analogue source ranges; codes above 3 fall back to frequency
    function automatic logic [50:0] src_range(input ana_src_t s, input drive_meas_t m,
                                              input logic [15:0] fmin, input logic [15:0] fmax,
                                              input logic [15:0] rated);
        unique case (s)
            3'h1: return {17'(m.out_current), 17'h00000, {rated, 1'b0}};
            3'h2: return {17'(m.bus_volt), 17'h00000, `SOS_BUS_FULL_V};
            3'h3: return {17'(m.out_volt), 17'h00000, `SOS_OUT_FULL_V};
            default: return {17'(m.out_freq), 17'(fmin), 17'(fmax)};
        endcase
    endfunction

    wire [50:0] v_rng = src_range(voltage_out_source_select_r, meas, min_freq_r, max_freq_r, rated_cur_r);
    wire [50:0] i_rng = src_range(current_out_source_select_r, meas, min_freq_r, max_freq_r, rated_cur_r);

    analog_scaler #(.VW(17), .OW(OUT_W)) u_vscale (
        .pclk(pclk),
        .presetn(presetn),
        .value(v_rng[50:34]),
        .lo(v_rng[33:17]),
        .hi(v_rng[16:0]),
        .scaled(analog_voltage_output)
    );

    analog_scaler #(.VW(17), .OW(OUT_W)) u_iscale (
        .pclk(pclk),
        .presetn(presetn),
        .value(i_rng[50:34]),
        .lo(i_rng[33:17]),
        .hi(i_rng[16:0]),
        .scaled(analog_current_output)
    );

endmodule

// File: verification/sos_monitor.sv
// checker for the status output selector, port-level only
// assumes selector writes seen on apb mirror the selector register
`timescale 1ns/1ps
`include "sos_params.svh"
module sos_monitor
    import sos_pkg::*;
#(parameter int STAGES = 8) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire drive_flags_t flags,
    input wire drive_meas_t meas,
    input wire logic program_clear,
    input wire logic winding_enable,
    input wire logic relay_output_one,
    input wire logic relay_output_two,
    input wire logic changeover_relay_output,
    input wire logic cable_alarm,
    input wire logic winding_active,
    input wire logic winding_hold,
    input wire logic [$clog2(STAGES)-1:0] program_step
);
    // codes are not ports, so rebuild them from bus writes
    logic [5:0] s1_r, s2_r, s3_r;
    wire sel_wr = psel & penable & pwrite & (paddr == `SOS_OFF_SEL);
    wire freq_hit = meas.out_freq >= meas.set_freq;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= `SOS_RST_R1;
            s2_r <= `SOS_RST_R2;
            s3_r <= `SOS_RST_CO;
        end else if (sel_wr) begin
            s1_r <= pwdata[5:0];
            s2_r <= pwdata[13:8];
            s3_r <= pwdata[21:16];
        end
    end
    // the design is still in reset at the edge that releases presetn, so skip that edge too
    logic live_r;
    always_ff @(posedge pclk) live_r <= presetn;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !live_r);
    property p_off; s1_r == 6'h00 |=> !relay_output_one; endproperty
    a_off: assert property (p_off) else $error("relay one set under code zero");
    property p_run; s1_r == 6'h01 |=> relay_output_one == $past(flags.running); endproperty
    a_run: assert property (p_run) else $error("relay one not tracking running");
    property p_freq; s2_r == 6'h02 |=> relay_output_two == $past(freq_hit); endproperty
    a_freq: assert property (p_freq) else $error("relay two not tracking frequency reached");
    property p_fault; s3_r == 6'h03 |=> changeover_relay_output == $past(flags.fault); endproperty
    a_fault: assert property (p_fault) else $error("changeover not tracking fault");
    property p_accel; s1_r == 6'h07 && flags.accel |=> relay_output_one; endproperty
    a_accel: assert property (p_accel) else $error("relay one missed accelerating");
    property p_load; s1_r == 6'h11 |=> relay_output_one == $past(flags.overload); endproperty
    a_load: assert property (p_load) else $error("relay one not tracking overload");
    property p_cable; flags.cable_open |=> cable_alarm; endproperty
    a_cable: assert property (p_cable) else $error("cable alarm missing");
    property p_wind_on; winding_enable && flags.running && !winding_active && !winding_hold |=> winding_active;
    endproperty
    a_wind_on: assert property (p_wind_on) else $error("winding did not start");
    property p_wind_out; s1_r == 6'h1A |=> relay_output_one == $past(winding_hold); endproperty
    a_wind_out: assert property (p_wind_out) else $error("winding complete output wrong");
    property p_clear; program_clear |=> program_step == '0; endproperty
    a_clear: assert property (p_clear) else $error("program step not cleared");
    c_count: cover property (s1_r == 6'h1B && relay_output_one);
    c_wind: cover property (winding_hold);
    c_clear: cover property (program_clear);
endmodule
bind status_output_selector sos_monitor #(.STAGES(STAGES)) mon_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .flags, .meas, .program_clear, .winding_enable, .relay_output_one, .relay_output_two,
    .changeover_relay_output, .cable_alarm, .winding_active, .winding_hold, .program_step);

// File: verification/terminal_model.sv
// terminal model: counter pulse source and contact closure counters
// assumes the bench calls burst and reads the closure counts
`timescale 1ns/1ps
module terminal_model #(parameter int GAP = 8) (
    input wire logic pclk,
    input wire logic relay_output_one,
    input wire logic relay_output_two,
    output logic counter_pulse,
    output int closures_one,
    output int closures_two
);
    logic one_q, two_q;
    initial begin
        counter_pulse = 1'b0;
        one_q = 1'b0;
        two_q = 1'b0;
        closures_one = 0;
        closures_two = 0;
    end
    always @(posedge pclk) begin
        one_q <= relay_output_one;
        two_q <= relay_output_two;
        if (relay_output_one && !one_q) closures_one <= closures_one + 1;
        if (relay_output_two && !two_q) closures_two <= closures_two + 1;
    end
    // spacing scaled down from the real pulse limit
    task automatic burst(input int n);
        repeat (n) begin
            counter_pulse <= 1'b1;
            repeat (GAP) @(posedge pclk);
            counter_pulse <= 1'b0;
            repeat (GAP) @(posedge pclk);
        end
    endtask
endmodule

// File: verification/status_output_selector_tb.sv
// self-checking bench for the status output selector
// assumes design, package and terminal model are compiled before it
`timescale 1ns/1ps
module status_output_selector_tb;
    import sos_pkg::*;
    typedef struct packed {logic [5:0] c; logic [10:0] f; logic [15:0] v; logic e;} row_t;
    // v feeds frequency, bus volts and pid feedback at once
    localparam row_t ROWS [22] = '{
        {6'h00, 11'h7FF, 16'h0100, 1'b0}, {6'h01, 11'h400, 16'h0100, 1'b1},
        {6'h02, 11'h000, 16'h0300, 1'b1}, {6'h02, 11'h000, 16'h02FF, 1'b0},
        {6'h03, 11'h200, 16'h0100, 1'b1}, {6'h04, 11'h000, 16'h0063, 1'b1},
        {6'h04, 11'h000, 16'h0064, 1'b0}, {6'h05, 11'h000, 16'h0200, 1'b1},
        {6'h06, 11'h000, 16'h03FF, 1'b0}, {6'h07, 11'h100, 16'h0100, 1'b1},
        {6'h08, 11'h080, 16'h0100, 1'b1}, {6'h09, 11'h000, 16'h00FF, 1'b1},
        {6'h09, 11'h000, 16'h0100, 1'b0}, {6'h0A, 11'h050, 16'h0100, 1'b1},
        {6'h0A, 11'h040, 16'h0100, 1'b0}, {6'h0B, 11'h028, 16'h0100, 1'b1},
        {6'h0E, 11'h000, 16'h0081, 1'b1}, {6'h0F, 11'h000, 16'h000F, 1'b1},
        {6'h0F, 11'h000, 16'h0010, 1'b0}, {6'h10, 11'h004, 16'h0100, 1'b1},
        {6'h12, 11'h001, 16'h0100, 1'b1}, {6'h21, 11'h7FF, 16'h0000, 1'b0}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, counter_pulse;
    logic step_program_mode, stage_done, counter_reset, program_clear, winding_enable, winding_done;
    logic relay_output_one, relay_output_two, changeover_relay_output, undervoltage_alarm, cable_alarm;
    logic winding_active, winding_hold;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] winding_hold_freq;
    logic [2:0] program_step;
    logic [11:0] analog_voltage_output, analog_current_output;
    drive_flags_t flags;
    drive_meas_t meas;
    int err_count, samples_checked, c1, c2;
    status_output_selector dut_u (.*);
    terminal_model term_u (.pclk, .relay_output_one, .relay_output_two, .counter_pulse,
        .closures_one(), .closures_two());
    always #5 pclk = ~pclk;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stages(input int n);
        repeat (n) begin
            stage_done <= 1'b1;
            @(posedge pclk);
            stage_done <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {step_program_mode, stage_done, counter_reset, program_clear, winding_enable, winding_done} = '0;
        flags = '0;
        meas = '0;
        meas.set_freq = 16'h0300;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00030201);
        apb(1'b0, 8'h44, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h0C, 32'h04000200);
        apb(1'b1, 8'h10, 32'h00000064);
        apb(1'b1, 8'h14, 32'h00000100);
        apb(1'b1, 8'h18, 32'h00100080);
        for (int i = 0; i < 22; i++) begin
            apb(1'b1, 8'h00, {16'h0003, 8'h02, 2'b00, ROWS[i].c});
            flags <= ROWS[i].f;
            meas.out_freq <= ROWS[i].v;
            meas.bus_volt <= ROWS[i].v;
            meas.pid_feedback <= ROWS[i].v;
            repeat (3) @(posedge pclk);
            chk(relay_output_one, ROWS[i].e);
            if (ROWS[i].c == 6'h09) chk(undervoltage_alarm, ROWS[i].e);
        end
        apb(1'b1, 8'h1C, 32'h00020004);
        apb(1'b1, 8'h00, 32'h00031C1B);
        term_u.burst(2);
        chk({relay_output_one, relay_output_two}, 2'b01);
        term_u.burst(3);
        apb(1'b0, 8'h2C, 32'h0);
        chk({relay_output_one, rd[30:0]}, {1'b1, 31'h4});
        counter_reset <= 1'b1;
        @(posedge pclk);
        counter_reset <= 1'b0;
        term_u.burst(1);
        apb(1'b0, 8'h2C, 32'h0);
        chk({relay_output_one, rd[30:0]}, {1'b0, 31'h1});
        apb(1'b1, 8'h00, 32'h00030D0C);
        step_program_mode <= 1'b1;
        c1 = term_u.closures_one;
        c2 = term_u.closures_two;
        stages(8);
        chk({8'(term_u.closures_one - c1), 8'(term_u.closures_two - c2), program_step}, {8'd8, 8'd1, 3'd0});
        stages(3);
        flags <= 11'h200;
        repeat (3) @(posedge pclk);
        chk(program_step, 3'd3);
        program_clear <= 1'b1;
        @(posedge pclk);
        program_clear <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(program_step, 3'd0);
        apb(1'b1, 8'h00, 32'h0003021A);
        flags <= 11'h400;
        meas.out_freq <= 16'h0777;
        winding_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(winding_active, 1'b1);
        winding_done <= 1'b1;
        @(posedge pclk);
        winding_done <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({winding_hold, relay_output_one, winding_hold_freq}, {2'b11, 16'h0777});
        flags <= 11'h000;
        repeat (3) @(posedge pclk);
        chk({winding_hold, relay_output_one}, 2'b00);
        meas.out_freq <= 16'h1388;
        meas.out_current <= 16'h00C8;
        repeat (3) @(posedge pclk);
        chk({analog_voltage_output, analog_current_output}, 24'hFFFFFF);
        apb(1'b1, 8'h04, 32'h00000302);
        meas.bus_volt <= 16'h03E8;
        meas.out_volt <= 16'h01FE;
        repeat (3) @(posedge pclk);
        chk({analog_voltage_output, analog_current_output}, 24'hFFFFFF);
        flags <= 11'h400;
        presetn <= 1'b0;
        @(posedge pclk);
        chk({relay_output_one, winding_active, analog_voltage_output}, 14'h0);
        presetn <= 1'b1;
        apb(1'b0, 8'h2C, 32'h0);
        chk(rd, 32'h0);
        chk({relay_output_one, relay_output_two}, 2'b11);
        tally_and_finish();
    end
endmodule
